// *** ep_mask_mem.sv ***
// Purpose: Endpoint interrupt mask words, one per endpoint.
// Assumes: One write and one read port, read data registered.
// Notes:   Reset clears every word so masks start disabled.
`timescale 1ns/1ps
`default_nettype none
`include "usb_pipe_regs_map.svh"
module ep_mask_mem (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic rd_en,
   input wire logic [3:0] rd_addr,
   output logic [31:0] rd_data
);
   // Storage words
   logic [31:0] words [0:`EP_COUNT-1];

   // Write port; reset walks all words to the reset value
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `EP_COUNT; i++) begin
            words[i] <= `MASK_RESET;
         end
      end else if (wr_en) begin
         words[wr_addr] <= wr_data;
      end
   end

   // Read port, one cycle latency
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= 32'h0000_0000;
      end else if (rd_en) begin
         rd_data <= words[rd_addr];
      end
   end
endmodule
`default_nettype wire

// *** event_irq.sv ***
// Purpose: Sticky event status, mask and one level interrupt.
// Assumes: Status bits clear by writing one.
// Notes:   A new event in the clearing cycle stays set.
`timescale 1ns/1ps
`default_nettype none
`include "usb_pipe_regs_map.svh"
module event_irq (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`EV_COUNT-1:0] events,
   input wire logic clr_we,
   input wire logic [`EV_COUNT-1:0] clr_data,
   input wire logic mask_we,
   input wire logic [`EV_COUNT-1:0] mask_data,
   output logic [`EV_COUNT-1:0] status,
   output logic [`EV_COUNT-1:0] mask,
   output logic irq
);
   // Sticky status; the set term is applied after the clear so it wins
   always_ff @(posedge clk) begin
      if (rst) begin
         status <= '0;
      end else begin
         status <= (status & ~(clr_we ? clr_data : '0)) | events;
      end
   end

   // Mask written by software
   always_ff @(posedge clk) begin
      if (rst) begin
         mask <= '0;
      end else if (mask_we) begin
         mask <= mask_data;
      end
   end

   // Level output from a flop, one cycle behind the status
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end
endmodule
`default_nettype wire

// *** usb_endpoint_pipe_regs.sv ***
// Purpose: APB register slice: isochronous endpoint mask clear view,
//          endpoint type words, host pipe 4..7 address word, events.
// Assumes: APB3 master; paddr and pwdata held through the access.
// Notes:   Every access answers two cycles after its first access edge.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "usb_pipe_regs_map.svh"
module usb_endpoint_pipe_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic usb_reset_req,
   output logic [31:0] pipe_device_addresses,
   output logic irq
);
   // Sequencer state
   usb_pipe_regs_pkg::bus_state_e state;
   // Every access cycle of a transfer not yet answered
   logic start;
   // Address decode
   logic clr_hit, mask_hit, cfg_hit, pipe_hit, stat_hit, imask_hit, any_hit;
   // Endpoint number of the addressed word
   logic [3:0] idx;
   // Endpoint type per endpoint
   logic [1:0] ep_type [0:`EP_COUNT-1];
   // Addressed endpoint is isochronous
   logic is_iso;
   // Mask memory ports
   logic mem_we;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;
   // Answer values
   logic [31:0] next_prdata;
   // Write strobe in the answering cycle
   logic step_wr;
   // Event pulses and interrupt registers
   logic [`EV_COUNT-1:0] events;
   logic [`EV_COUNT-1:0] ev_status;
   logic [`EV_COUNT-1:0] ev_mask;

   // pready in the term stops a held access from starting a second time
   assign start = psel && penable && !pready;

   // Decode the held address
   always_comb begin
      clr_hit = usb_pipe_regs_pkg::ep_hit(paddr, `CLR_BASE);
      mask_hit = usb_pipe_regs_pkg::ep_hit(paddr, `MASK_BASE);
      cfg_hit = usb_pipe_regs_pkg::ep_hit(paddr, `CFG_BASE);
      pipe_hit = (paddr == `PIPE_ADDR_OFS);
      stat_hit = (paddr == `IRQ_STAT_OFS);
      imask_hit = (paddr == `IRQ_MASK_OFS);
      any_hit = clr_hit || mask_hit || cfg_hit || pipe_hit || stat_hit || imask_hit;
   end

   // Endpoint number, taken from whichever array is hit
   always_comb begin
      if (clr_hit) begin
         idx = usb_pipe_regs_pkg::ep_index(paddr, `CLR_BASE);
      end else if (mask_hit) begin
         idx = usb_pipe_regs_pkg::ep_index(paddr, `MASK_BASE);
      end else if (cfg_hit) begin
         idx = usb_pipe_regs_pkg::ep_index(paddr, `CFG_BASE);
      end else begin
         idx = 4'h0;
      end
   end

   // Type check against the isochronous code
   assign is_iso = (ep_type[idx] == `TYPE_ISO);

   // Two-step sequencer: fetch the mask word, then answer
   // Fixed latency keeps the mask read-modify-write inside one step
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= usb_pipe_regs_pkg::ST_IDLE;
      end else begin
         unique case (state)
            usb_pipe_regs_pkg::ST_IDLE: begin
               if (start) begin
                  state <= usb_pipe_regs_pkg::ST_STEP;
               end
            end
            usb_pipe_regs_pkg::ST_STEP: begin
               state <= usb_pipe_regs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Step cycle write strobe; every write effect keys off it exactly once
   assign step_wr = (state == usb_pipe_regs_pkg::ST_STEP) && pwrite;

   // Mask update: direct write, or clear-where-one on an iso endpoint.
   // A clear on another type is dropped rather than reinterpreted.
   always_comb begin
      mem_we = step_wr && (mask_hit || (clr_hit && is_iso));
      if (mask_hit) begin
         mem_wdata = pwdata;
      end else begin
         mem_wdata = mem_rdata & ~pwdata;
      end
   end

   // Mask words live in their own memory
   ep_mask_mem u_mask (
      .clk(clk),
      .rst(rst),
      .wr_en(mem_we),
      .wr_addr(idx),
      .wr_data(mem_wdata),
      .rd_en(start),
      .rd_addr(idx),
      .rd_data(mem_rdata)
   );

   // Endpoint type words
   // Only the type field is kept; other configuration bits read as zero
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `EP_COUNT; i++) begin
            ep_type[i] <= 2'h0;
         end
      end else if (step_wr && cfg_hit) begin
         ep_type[idx] <= pwdata[`TYPE_LSB+1:`TYPE_LSB];
      end
   end

   // Pipe addresses; a USB reset request beats a software write
   // Reserved lanes are masked on the way in, so they can never read back
   always_ff @(posedge clk) begin
      if (rst) begin
         pipe_device_addresses <= `PIPE_ADDR_RESET;
      end else if (usb_reset_req) begin
         pipe_device_addresses <= `PIPE_ADDR_RESET;
      end else if (step_wr && pipe_hit) begin
         pipe_device_addresses <= pwdata & `PIPE_LIVE_MASK;
      end
   end

   // Events: ignored clear on a non-iso endpoint, USB reset applied
   // Bit 0 lets software see that a clear met an endpoint of another type
   always_comb begin
      events = '0;
      events[`EV_IGNORED] = step_wr && clr_hit && !is_iso;
      events[`EV_USB_RESET] = usb_reset_req;
   end

   // Sticky status, mask and level output of the event bits
   event_irq u_irq (
      .clk(clk),
      .rst(rst),
      .events(events),
      .clr_we(step_wr && stat_hit),
      .clr_data(pwdata[`EV_COUNT-1:0]),
      .mask_we(step_wr && imask_hit),
      .mask_data(pwdata[`EV_COUNT-1:0]),
      .status(ev_status),
      .mask(ev_mask),
      .irq(irq)
   );

   // Read data; the clear view has no readable state at all
   // Unmapped reads fall through to zero alongside the error
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
         if (clr_hit) begin
            next_prdata = 32'h0000_0000;
         end else if (mask_hit) begin
            next_prdata = mem_rdata;
         end else if (cfg_hit) begin
            next_prdata[`TYPE_LSB+1:`TYPE_LSB] = ep_type[idx];
         end else if (pipe_hit) begin
            next_prdata = pipe_device_addresses & `PIPE_LIVE_MASK;
         end else if (stat_hit) begin
            next_prdata[`EV_COUNT-1:0] = ev_status;
         end else if (imask_hit) begin
            next_prdata[`EV_COUNT-1:0] = ev_mask;
         end
      end
   end

   // Answer flops: ready for one cycle, error on unmapped addresses
   // prdata is forced to zero between answers so stale data never shows
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (state == usb_pipe_regs_pkg::ST_STEP) begin
         pready <= 1'b1;
         pslverr <= !any_hit;
         prdata <= next_prdata;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

   // Checks of the bus answer, the mask update, the pipe word and events
   // Helper: a write into the clear view being answered
   sequence clr_write_step;
      state == usb_pipe_regs_pkg::ST_STEP && pwrite && clr_hit;
   endsequence

   // Helper: an access that has just begun
   sequence access_begins;
      start && state == usb_pipe_regs_pkg::ST_IDLE;
   endsequence

   iso_gate_a: assert property (@(posedge clk) disable iff (rst)
      clr_write_step and !is_iso |-> !mem_we ##1 ev_status[`EV_IGNORED])
      else $error("mask changed by clear on non-iso endpoint");

   clear_reads_zero_a: assert property (@(posedge clk) disable iff (rst)
      access_begins and !pwrite && clr_hit |-> ##2 pready && prdata == 32'h0000_0000)
      else $error("clear view read back nonzero");

   mask_clear_a: assert property (@(posedge clk) disable iff (rst)
      clr_write_step and is_iso |-> mem_we && (mem_wdata & pwdata) == 32'h0000_0000
      && (mem_wdata | pwdata) == (mem_rdata | pwdata))
      else $error("clear did not act bit by bit");

   named_bits_a: assert property (@(posedge clk) disable iff (rst)
      clr_write_step and is_iso && pwdata[`ERR_CLR_BIT] && pwdata[`DMA_DIS_CLR_BIT]
      |-> !mem_wdata[`ERR_CLR_BIT] && !mem_wdata[`DMA_DIS_CLR_BIT])
      else $error("bit 10 or 16 not cleared");

   // Reset leaves every pipe address at zero
   pipe_reset_a: assert property (@(posedge clk)
      rst |=> pipe_device_addresses == 32'h0000_0000)
      else $error("pipe addresses not zero after reset");

   // A request clears the word at the next edge and flags its event
   usb_reset_a: assert property (@(posedge clk) disable iff (rst)
      usb_reset_req |=> pipe_device_addresses == 32'h0000_0000 ##1 ev_status[`EV_USB_RESET])
      else $error("usb reset did not clear pipe addresses");

   // Lanes 7, 15, 23 and 31 never hold a one
   pipe_reserved_a: assert property (@(posedge clk) disable iff (rst)
      (pipe_device_addresses & ~`PIPE_LIVE_MASK) == 32'h0000_0000)
      else $error("reserved pipe address bit set");

   // Answer two edges after the access edge, for exactly one cycle
   answer_timing_a: assert property (@(posedge clk) disable iff (rst)
      access_begins |-> !pready ##1 !pready ##1 pready ##1 !pready)
      else $error("answer not two cycles after access");

   // Helper: a write into the event status word being applied
   sequence stat_clear_step;
      state == usb_pipe_regs_pkg::ST_STEP && pwrite && stat_hit;
   endsequence

   // A reset request landing with the clear of its own bit keeps the bit set
   set_wins_a: assert property (@(posedge clk) disable iff (rst)
      stat_clear_step and pwdata[`EV_USB_RESET] && usb_reset_req
      |=> ev_status[`EV_USB_RESET])
      else $error("event lost to a same-cycle clear");

   // A written one clears a quiet event bit at the step edge
   stat_clear_a: assert property (@(posedge clk) disable iff (rst)
      stat_clear_step and pwdata[`EV_USB_RESET] && !usb_reset_req
      |=> !ev_status[`EV_USB_RESET])
      else $error("status bit not cleared by a written one");

   // The level output follows any unmasked pending event one edge later
   irq_on_a: assert property (@(posedge clk) disable iff (rst)
      (ev_status & ev_mask) != '0 |=> irq)
      else $error("pending unmasked event without interrupt");

   // With nothing unmasked pending the output drops one edge later
   irq_off_a: assert property (@(posedge clk) disable iff (rst)
      (ev_status & ev_mask) == '0 |=> !irq)
      else $error("interrupt with no unmasked event");

   // The error flag only ever travels with the answer
   error_with_ready_a: assert property (@(posedge clk) disable iff (rst)
      pslverr |-> pready)
      else $error("error flag outside an answer");

   // An unmapped access is answered on time with the error and zero data
   unmapped_refused_a: assert property (@(posedge clk) disable iff (rst)
      access_begins and !any_hit |-> ##2 pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   // Between answers the read bus and the error flag rest at zero
   idle_data_zero_a: assert property (@(posedge clk) disable iff (rst)
      !pready |-> prdata == 32'h0000_0000 && !pslverr)
      else $error("read bus not quiet between answers");

   // A software write lands in the live lanes when no bus reset competes
   pipe_write_a: assert property (@(posedge clk) disable iff (rst)
      step_wr && pipe_hit && !usb_reset_req
      |=> pipe_device_addresses == ($past(pwdata) & `PIPE_LIVE_MASK))
      else $error("pipe address write did not land");
endmodule
`default_nettype wire

// *** usb_endpoint_pipe_regs_bench.sv ***
// Purpose: Self-checking bench of the endpoint clear view and pipe address slice.
// Assumes: APB answers after a few cycles; read results checked from a queue.
// Notes:   Seed 4; the watchdog ends a hung run through print_verdict.
`timescale 1ns/1ps
`default_nettype none
`include "usb_pipe_regs_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module usb_endpoint_pipe_regs_bench;
   logic clk, rst, psel, penable, pwrite, usb_reset_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, pipe_device_addresses, m, c, r;
   logic pready, pslverr, irq;
   logic [33:0] exp_q[$]; // Notes: {error, is_read, data}
   logic [33:0] cur;
   int failures = 0;
   int n_checks = 0;
   int x;

   usb_endpoint_pipe_regs uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .usb_reset_req(usb_reset_req),
      .pipe_device_addresses(pipe_device_addresses), .irq(irq));

   // 200 MHz clock
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end

   // Verdict and end of run, shared with the watchdog
   task automatic print_verdict();
      if (failures == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One APB transfer; the expectation is noted before the request goes out
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
      exp_q.push_back({er, ~w, e});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Request held until pready is seen high at an edge
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so the next setup never rewrites psel in this time step
      @(posedge clk);
   endtask

   // Watcher: each answer takes the oldest note off the queue
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, pready, 1'b0);
         end else begin
            cur = exp_q.pop_front();
            `CHK(pslverr, cur[33])
            if (cur[32]) begin
               `CHK(prdata, cur[31:0])
            end
         end
      end
   end

   // Watchdog sized well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      print_verdict();
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      usb_reset_req = 1'b0;
      void'($urandom(4));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values of the address word, the mask word of endpoint 0 and clear view
      apb(`PIPE_ADDR_OFS, 0, 0, `PIPE_ADDR_RESET, 0);
      apb(`MASK_BASE, 0, 0, `MASK_RESET, 0);
      apb(`CLR_BASE, 0, 0, 32'h0000_0000, 0);
      // Unused bits never stick; random fields land in their own lanes
      apb(`PIPE_ADDR_OFS, 1, 32'hFFFF_FFFF, 0, 0);
      apb(`PIPE_ADDR_OFS, 0, 0, 32'h7F7F_7F7F, 0);
      r = $urandom();
      apb(`PIPE_ADDR_OFS, 1, r, 0, 0);
      apb(`PIPE_ADDR_OFS, 0, 0, r & `PIPE_LIVE_MASK, 0);
      `CHK(pipe_device_addresses, r & `PIPE_LIVE_MASK)
      // Bus reset request zeroes every field, and flags event 1
      usb_reset_req <= 1'b1;
      @(posedge clk);
      usb_reset_req <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(pipe_device_addresses, 32'h0000_0000)
      `CHK(irq, 1'b0)
      // Reset request held across a write still wins
      usb_reset_req <= 1'b1;
      apb(`PIPE_ADDR_OFS, 1, 32'h1234_5678, 0, 0);
      usb_reset_req <= 1'b0;
      apb(`PIPE_ADDR_OFS, 0, 0, 32'h0000_0000, 0);
      // Every endpoint: even ones isochronous, odd ones bulk type
      for (x = 0; x < `EP_COUNT; x++) begin
         m = $urandom();
         c = (x < 2) ? 32'h0001_0400 : $urandom();
         r = (x % 2 == 0) ? 32'h0000_0800 : 32'h0000_1000;
         apb(`CFG_BASE + 12'(4 * x), 1, r, 0, 0);
         apb(`CFG_BASE + 12'(4 * x), 0, 0, r, 0);
         apb(`MASK_BASE + 12'(4 * x), 1, m, 0, 0);
         apb(`CLR_BASE + 12'(4 * x), 1, c, 0, 0);
         apb(`CLR_BASE + 12'(4 * x), 0, 0, 32'h0000_0000, 0);
         apb(`MASK_BASE + 12'(4 * x), 0, 0, (x % 2 == 0) ? (m & ~c) : m, 0);
      end
      // Unmapped place is refused
      apb(12'h7FC, 0, 0, 32'h0000_0000, 1);
      // Both events pending; irq stays low while masked
      apb(`IRQ_STAT_OFS, 0, 0, 32'h0000_0003, 0);
      `CHK(irq, 1'b0)
      apb(`IRQ_MASK_OFS, 1, 32'h0000_0002, 0, 0);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      // Clearing the unmasked bit drops irq, the other stays sticky
      apb(`IRQ_STAT_OFS, 1, 32'h0000_0002, 0, 0);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      apb(`IRQ_STAT_OFS, 0, 0, 32'h0000_0001, 0);
      apb(`IRQ_MASK_OFS, 0, 0, 32'h0000_0002, 0);
      // Reset request during the clear of its own bit: the event wins
      usb_reset_req <= 1'b1;
      apb(`IRQ_STAT_OFS, 1, 32'h0000_0002, 0, 0);
      usb_reset_req <= 1'b0;
      apb(`IRQ_STAT_OFS, 0, 0, 32'h0000_0003, 0);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule
`default_nettype wire

// *** usb_pipe_regs_map.svh ***
// Purpose: Offsets, field positions, reset values and codes of the
//          endpoint clear view and host pipe address register slice.
// Assumes: Included by bare name; definitions only.
// Notes:   Byte offsets on a 32-bit APB, one register per word.
// Operation
// - Clear view acts only on isochronous endpoints
// - Clear view always reads back as zero
// - One clears mask bit, zero leaves it
// - Separate clear bits at 10 and 16
// - Four 7-bit pipe addresses, reset zero
// - USB reset request zeroes all pipe addresses
`ifndef USB_PIPE_REGS_MAP_SVH
`define USB_PIPE_REGS_MAP_SVH

// Number of endpoints that own a clear view and a mask word
`define EP_COUNT 10
// Register offsets
`define CLR_BASE 12'h1F0
`define MASK_BASE 12'h220
`define CFG_BASE 12'h100
`define PIPE_ADDR_OFS 12'h428
`define IRQ_STAT_OFS 12'h500
`define IRQ_MASK_OFS 12'h504
// Endpoint type field inside the configuration word
`define TYPE_LSB 11
`define TYPE_ISO 2'h1
// Clear bits named out in the clear view
`define ERR_CLR_BIT 10
`define DMA_DIS_CLR_BIT 16
// Pipe address layout: live bits only
`define PIPE_LIVE_MASK 32'h7F7F_7F7F
`define PIPE_ADDR_RESET 32'h0000_0000
`define MASK_RESET 32'h0000_0000
// Interrupt event bits
`define EV_COUNT 2
`define EV_IGNORED 0
`define EV_USB_RESET 1

`endif

// *** usb_pipe_regs_pkg.sv ***
// Purpose: Types and shared decode helpers of the register slice.
// Assumes: Offsets come from usb_pipe_regs_map.svh.
// Notes:   Nothing here is imported; users write the package name.
`include "usb_pipe_regs_map.svh"
package usb_pipe_regs_pkg;
   // Bus sequencer states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_STEP = 1'b1
   } bus_state_e;

   // True when addr lies in the endpoint word array at base
   function automatic logic ep_hit(input logic [11:0] addr, input logic [11:0] base);
      logic [11:0] d;
      d = addr - base;
      return (addr >= base) && (d < 12'(4 * `EP_COUNT)) && (addr[1:0] == 2'h0);
   endfunction

   // Endpoint number of a word inside the array at base
   function automatic logic [3:0] ep_index(input logic [11:0] addr, input logic [11:0] base);
      logic [11:0] d;
      d = addr - base;
      return d[5:2];
   endfunction
endpackage
